//--- src/pmt_panel.sv
// Purpose: Front-panel menu, measurement screens and trip display of a protection monitor
// Assumes: Front end on pclk; buttons are raw active-low pins
// Notes:   Zero-wait APB slave; one ms tick drives every slow timer
// Overview of operation
// - Trip opens relay, flashes backlight
// - Show latched trip cause code
// - Escape: home screen, or leave menu
// - Escape discards edit; manual reset in error
// - Set enters menu, edit, then stores
// - Up: next group, parameter, increment
// - Down: variants, parameter, decrement
// - Down cycles all screens then home
// - Up visits group heads, wraps home
// - Home screen first after power up
// - Home voltages follow protection type
// - Relay closed and open indicator
// - Phase rotation correct or reversed indicator
// - Phase, type, variant, comm indicators
// - Password gates menu, voltage group first
// - Demand interval edited, stored or abandoned
// - Auto or manual reclose after recovery
`timescale 1ns/100ps
`default_nettype none
`include "pmt_map.svh"

module pmt_panel #(
  parameter int TICK_CYCLES = `PMT_TICK_US * `PMT_CLK_MHZ
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        btn_n,
  input  wire logic              trip_active,
  input  wire logic [3:0]        trip_cause,
  input  wire logic              restore_ok,
  input  wire logic              phase_order_ok,
  input  wire logic              comm_active,
  output logic                   relay_close,
  output logic                   backlight_on,
  output pmt_pkg::pmt_disp_t     disp,
  output logic                   irq
);
  import pmt_pkg::*;

  localparam logic [16:0] TICK_MAX    = 17'(TICK_CYCLES - 1);
  localparam logic [11:0] DEB_TICKS   = 12'(`PMT_DEBOUNCE_MS);
  localparam logic [11:0] BLINK_TICKS = 12'(`PMT_BLINK_MS);
  localparam logic [11:0] PHASE_TICKS = 12'(`PMT_PHASE_MS);
  localparam logic [11:0] REST_TICKS  = 12'(`PMT_RESTORE_MS);

  function automatic logic [2:0] grp_of(input logic [4:0] s);
    if (s == 5'd0)       return 3'd0;
    else if (s < 5'd5)   return 3'd1;
    else if (s < 5'd9)   return 3'd2;
    else if (s < 5'd14)  return 3'd3;
    else if (s < 5'd19)  return 3'd4;
    else                 return 3'd5;
  endfunction : grp_of

  function automatic logic [4:0] head_of(input logic [2:0] g);
    case (g)
      3'd1:    return 5'd1;
      3'd2:    return 5'd5;
      3'd3:    return 5'd9;
      3'd4:    return 5'd14;
      3'd5:    return 5'd19;
      default: return 5'd0;
    endcase
  endfunction : head_of

  // ms tick divider
  logic [16:0] div_q, div_d;
  logic        tick;

  always_comb begin
    tick  = (div_q == TICK_MAX);
    div_d = tick ? 17'h0_0000 : div_q + 17'h0_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 17'h0_0000;
    else          div_q <= div_d;
  end

  // Buttons: two-flop sync, then debounce on stable level
  logic [3:0]  sy1_q, sy2_q, deb_q, deb_d, press;
  logic [11:0] dcnt_q [4];
  logic [11:0] dcnt_d [4];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      deb_d[i]  = deb_q[i];
      dcnt_d[i] = dcnt_q[i];
      if (sy2_q[i] == deb_q[i]) begin
        dcnt_d[i] = 12'h000;
      end else if (tick) begin
        if (dcnt_q[i] + 12'h001 >= DEB_TICKS) begin
          deb_d[i]  = sy2_q[i];
          dcnt_d[i] = 12'h000;
        end else begin
          dcnt_d[i] = dcnt_q[i] + 12'h001;
        end
      end
    end
    press = deb_d & ~deb_q & {4{tick}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
      deb_q <= 4'h0;
      for (int i = 0; i < 4; i++) dcnt_q[i] <= 12'h000;
    end else begin
      sy1_q <= ~btn_n;
      sy2_q <= sy1_q;
      deb_q <= deb_d;
      for (int i = 0; i < 4; i++) dcnt_q[i] <= dcnt_d[i];
    end
  end

  logic b_esc, b_set, b_up, b_dn;
  assign b_esc = press[BTN_ESC];
  assign b_set = press[BTN_SET];
  assign b_up  = press[BTN_UP];
  assign b_dn  = press[BTN_DOWN];

  // Registers written by software
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] pwd_q, pwd_d, dem_q, dem_d;
  logic [3:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic       wr_en, rd_en;
  logic [31:0] rdata_d;

  // User interface state
  pmt_ui_t    st_q, st_d;
  logic [4:0] scr_q, scr_d;
  logic [2:0] grp_q, grp_d;
  logic [7:0] edit_q, edit_d, code_q, code_d;
  logic [3:0] err_q, err_d;
  logic       relay_q, relay_d;
  logic [11:0] rcnt_q, rcnt_d, bcnt_q, bcnt_d, pcnt_q, pcnt_d;
  logic       blink_q, blink_d;
  logic [1:0] ph_q, ph_d;
  logic       store_ev, leave_err;

  always_comb begin
    st_d      = st_q;
    scr_d     = scr_q;
    grp_d     = grp_q;
    edit_d    = edit_q;
    code_d    = code_q;
    err_d     = err_q;
    relay_d   = relay_q;
    rcnt_d    = rcnt_q;
    store_ev  = 1'b0;
    leave_err = 1'b0;
    ev        = 4'h0;
    if (trip_active && st_q != ST_ERR) begin
      st_d    = ST_ERR;
      err_d   = trip_cause;
      relay_d = 1'b0;
      rcnt_d  = 12'h000;
      ev[`PMT_IRQ_TRIP] = 1'b1;
    end else begin
      unique case (st_q)
        ST_MEAS: begin
          if (b_esc) begin
            scr_d = 5'd0;
          end else if (b_set) begin
            st_d   = ST_PASS;
            code_d = 8'h00;
          end else if (b_up) begin
            scr_d = (grp_of(scr_q) == 3'd5) ? 5'd0 : head_of(grp_of(scr_q) + 3'd1);
          end else if (b_dn) begin
            scr_d = (scr_q == `PMT_SCREENS - 5'd1) ? 5'd0 : scr_q + 5'd1;
          end
        end
        ST_PASS: begin
          if (b_esc) begin
            st_d = ST_MEAS;
          end else if (b_up) begin
            code_d = code_q + 8'h01;
          end else if (b_dn) begin
            code_d = code_q - 8'h01;
          end else if (b_set) begin
            if (code_q == pwd_q) begin
              st_d  = ST_MENU;
              grp_d = 3'd0;
            end else begin
              st_d = ST_MEAS;
              ev[`PMT_IRQ_PASS_FAIL] = 1'b1;
            end
          end
        end
        ST_MENU: begin
          if (b_esc) begin
            st_d = ST_MEAS;
          end else if (b_up) begin
            grp_d = (grp_q == `PMT_GROUPS - 3'd1) ? 3'd0 : grp_q + 3'd1;
          end else if (b_dn) begin
            grp_d = (grp_q == 3'd0) ? `PMT_GROUPS - 3'd1 : grp_q - 3'd1;
          end else if (b_set && grp_q == 3'd4) begin
            st_d   = ST_EDIT;
            edit_d = dem_q;
          end
        end
        ST_EDIT: begin
          if (b_esc) begin
            st_d = ST_MENU;
          end else if (b_set) begin
            st_d     = ST_MENU;
            store_ev = 1'b1;
            ev[`PMT_IRQ_STORED] = 1'b1;
          end else if (b_up && edit_q < `PMT_DEMAND_MAX) begin
            edit_d = edit_q + 8'h01;
          end else if (b_dn && edit_q > `PMT_DEMAND_MIN) begin
            edit_d = edit_q - 8'h01;
          end
        end
        ST_ERR: begin
          // Latched until recovery, even if the cause drops early
          if (!restore_ok || trip_active) begin
            rcnt_d = 12'h000;
          end else if (b_esc) begin
            leave_err = 1'b1;
          end else if (ctrl_q[`PMT_CTRL_AUTO_BIT] && tick) begin
            if (rcnt_q + 12'h001 >= REST_TICKS) leave_err = 1'b1;
            else rcnt_d = rcnt_q + 12'h001;
          end
          if (leave_err) begin
            st_d    = ST_MEAS;
            scr_d   = 5'd0;
            relay_d = 1'b1;
            rcnt_d  = 12'h000;
            ev[`PMT_IRQ_RESTORE] = 1'b1;
          end
        end
        default: st_d = ST_MEAS;
      endcase
    end
  end

  // Flashing backlight and phase indicator rotation
  always_comb begin
    bcnt_d  = bcnt_q;
    blink_d = blink_q;
    pcnt_d  = pcnt_q;
    ph_d    = ph_q;
    if (st_q != ST_ERR) begin
      bcnt_d  = 12'h000;
      blink_d = 1'b1;
    end else if (tick) begin
      if (bcnt_q + 12'h001 >= BLINK_TICKS) begin
        bcnt_d  = 12'h000;
        blink_d = ~blink_q;
      end else begin
        bcnt_d = bcnt_q + 12'h001;
      end
    end
    if (tick) begin
      if (pcnt_q + 12'h001 >= PHASE_TICKS) begin
        pcnt_d = 12'h000;
        ph_d   = (ph_q == 2'd3) ? 2'd1 : ph_q + 2'd1;
      end else begin
        pcnt_d = pcnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_MEAS;
      scr_q   <= 5'd0;
      grp_q   <= 3'd0;
      edit_q  <= 8'h00;
      code_q  <= 8'h00;
      err_q   <= 4'h0;
      relay_q <= 1'b1;
      rcnt_q  <= 12'h000;
      bcnt_q  <= 12'h000;
      blink_q <= 1'b1;
      pcnt_q  <= 12'h000;
      ph_q    <= 2'd1;
    end else begin
      st_q    <= st_d;
      scr_q   <= scr_d;
      grp_q   <= grp_d;
      edit_q  <= edit_d;
      code_q  <= code_d;
      err_q   <= err_d;
      relay_q <= relay_d;
      rcnt_q  <= rcnt_d;
      bcnt_q  <= bcnt_d;
      blink_q <= blink_d;
      pcnt_q  <= pcnt_d;
      ph_q    <= ph_d;
    end
  end

  // Display word
  pmt_disp_t disp_d;
  logic      bl_d;
  logic [4:0] off;

  always_comb begin
    off              = scr_q - head_of(grp_of(scr_q));
    disp_d.ui        = st_q;
    disp_d.screen    = scr_q;
    disp_d.meas_type = pmt_meas_t'(grp_of(scr_q));
    disp_d.variant   = 4'h0;
    if (off != 5'd0) disp_d.variant[off[1:0] - 2'd1] = 1'b1;
    disp_d.home_ll      = ctrl_q[`PMT_CTRL_LL_BIT];
    disp_d.phase_num    = ph_q;
    disp_d.relay_closed = relay_q;
    disp_d.rot_ok       = phase_order_ok;
    disp_d.comm_on      = comm_active;
    disp_d.err_show     = (st_q == ST_ERR);
    disp_d.err_code     = err_q;
    disp_d.menu_group   = grp_q;
    disp_d.edit_value   = (st_q == ST_PASS) ? code_q : edit_q;
    bl_d                = (st_q == ST_ERR) ? blink_q : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp         <= '0;
      relay_close  <= 1'b1;
      backlight_on <= 1'b1;
    end else begin
      disp         <= disp_d;
      relay_close  <= relay_q;
      backlight_on <= bl_d;
    end
  end

  // APB slave, zero wait states
  logic hit;
  always_comb begin
    hit = (paddr == `PMT_OFF_CTRL) || (paddr == `PMT_OFF_PASSWORD) || (paddr == `PMT_OFF_DEMAND) ||
          (paddr == `PMT_OFF_STATUS) || (paddr == `PMT_OFF_IRQ_STAT) || (paddr == `PMT_OFF_IRQ_MASK);
    pready  = 1'b1;
    pslverr = psel & penable & ~hit;
    wr_en   = psel & penable & pwrite & hit;
    rd_en   = psel & ~penable & ~pwrite;
    ctrl_d  = ctrl_q;
    pwd_d   = pwd_q;
    dem_d   = dem_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (wr_en) begin
      unique case (paddr)
        `PMT_OFF_CTRL:     ctrl_d  = pwdata[1:0];
        `PMT_OFF_PASSWORD: pwd_d   = pwdata[7:0];
        `PMT_OFF_DEMAND:   dem_d   = pwdata[7:0];
        `PMT_OFF_IRQ_STAT: ist_d   = ist_q & ~pwdata[3:0];
        `PMT_OFF_IRQ_MASK: imask_d = pwdata[3:0];
        default: ;
      endcase
    end
    // Panel store beats a same-cycle software write; set beats clear
    if (store_ev) dem_d = edit_q;
    ist_d = ist_d | ev;
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      `PMT_OFF_CTRL:     rdata_d[1:0] = ctrl_q;
      `PMT_OFF_PASSWORD: rdata_d[7:0] = pwd_q;
      `PMT_OFF_DEMAND:   rdata_d[7:0] = dem_q;
      `PMT_OFF_STATUS:   rdata_d[15:0] = {relay_q, err_q, st_q, scr_q, 3'b000};
      `PMT_OFF_IRQ_STAT: rdata_d[3:0] = ist_q;
      `PMT_OFF_IRQ_MASK: rdata_d[3:0] = imask_q;
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `PMT_RST_CTRL;
      pwd_q   <= `PMT_RST_PASSWORD;
      dem_q   <= `PMT_RST_DEMAND;
      ist_q   <= 4'h0;
      imask_q <= 4'h0;
      prdata  <= 32'h0000_0000;
      irq     <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      pwd_q   <= pwd_d;
      dem_q   <= dem_d;
      ist_q   <= ist_d;
      imask_q <= imask_d;
      if (rd_en) prdata <= rdata_d;
      irq     <= |(ist_d & imask_d);
    end
  end

endmodule : pmt_panel

`default_nettype wire

//--- shared/pmt_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the panel controller
// Assumes: 125 MHz pclk, APB byte addresses
// Notes:   Timing figures are kept in their own unit and converted in the module
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

`define PMT_OFF_CTRL       8'h00
`define PMT_OFF_PASSWORD   8'h04
`define PMT_OFF_DEMAND     8'h08
`define PMT_OFF_STATUS     8'h0C
`define PMT_OFF_IRQ_STAT   8'h10
`define PMT_OFF_IRQ_MASK   8'h14

`define PMT_CTRL_AUTO_BIT  0
`define PMT_CTRL_LL_BIT    1

`define PMT_IRQ_TRIP       0
`define PMT_IRQ_RESTORE    1
`define PMT_IRQ_STORED     2
`define PMT_IRQ_PASS_FAIL  3

`define PMT_RST_CTRL       2'h1
`define PMT_RST_PASSWORD   8'h00
`define PMT_RST_DEMAND     8'h0F
`define PMT_DEMAND_MIN     8'h01
`define PMT_DEMAND_MAX     8'h3C

`define PMT_CLK_MHZ        125
`define PMT_TICK_US        1000
`define PMT_DEBOUNCE_MS    20
`define PMT_BLINK_MS       250
`define PMT_PHASE_MS       1000
`define PMT_RESTORE_MS     3000

`define PMT_SCREENS        5'd23
`define PMT_GROUPS         3'd6

`endif

//--- shared/pmt_pkg.sv
// Purpose: Types shared by the panel controller and its bench
// Assumes: Constants live in pmt_map.svh
// Notes:   Display fields travel as one packed struct
package pmt_pkg;

  typedef enum logic [2:0] {
    ST_MEAS = 3'b000,
    ST_PASS = 3'b001,
    ST_MENU = 3'b010,
    ST_EDIT = 3'b011,
    ST_ERR  = 3'b100
  } pmt_ui_t;

  // Button index into the four-bit button bus
  typedef enum logic [1:0] {
    BTN_ESC  = 2'b00,
    BTN_SET  = 2'b01,
    BTN_UP   = 2'b10,
    BTN_DOWN = 2'b11
  } pmt_btn_t;

  typedef enum logic [2:0] {
    MT_HOME = 3'b000,
    MT_VLN  = 3'b001,
    MT_VLL  = 3'b010,
    MT_CUR  = 3'b011,
    MT_PWR  = 3'b100,
    MT_FRQ  = 3'b101
  } pmt_meas_t;

  typedef struct packed {
    pmt_ui_t   ui;
    logic [4:0] screen;
    pmt_meas_t meas_type;
    logic [3:0] variant;     // bit0 min, bit1 max, bit2 avg, bit3 demand
    logic       home_ll;
    logic [1:0] phase_num;
    logic       relay_closed;
    logic       rot_ok;
    logic       comm_on;
    logic       err_show;
    logic [3:0] err_code;
    logic [2:0] menu_group;
    logic [7:0] edit_value;
  } pmt_disp_t;

endpackage : pmt_pkg

//--- tb/pmt_panel_checker.sv
// Purpose: Port checks of the panel controller
// Assumes: Display fields trail the state by one cycle
// Notes:   Two-cycle bounds absorb that lag
`timescale 1ns/100ps
`default_nettype none
module pmt_panel_checker
  import pmt_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic               pslverr,
  input wire logic               trip_active,
  input wire logic [3:0]         trip_cause,
  input wire logic               restore_ok,
  input wire logic               phase_order_ok,
  input wire logic               comm_active,
  input wire logic               relay_close,
  input wire logic               backlight_on,
  input wire pmt_pkg::pmt_disp_t disp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] hold_q, hold_d;
  logic        bl_q, bl_d;

  // Cycles the backlight sits still in error
  always_comb begin
    bl_d   = backlight_on;
    hold_d = 32'h0000_0000;
    if (disp.ui == ST_ERR && backlight_on == bl_q) begin
      hold_d = hold_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 32'h0000_0000;
      bl_q   <= 1'b1;
    end else begin
      hold_q <= hold_d;
      bl_q   <= bl_d;
    end
  end

  relay_trip_a: assert property ($rose(trip_active) |-> ##[1:2] !relay_close)
    else $error("relay not opened");
  trip_state_a: assert property (trip_active |-> ##[1:2] disp.ui == ST_ERR)
    else $error("no error state");
  hold_open_a: assert property (!relay_close && (trip_active || !restore_ok) |=> !relay_close)
    else $error("relay closed early");
  light_steady_a: assert property ((disp.ui != ST_ERR) [*3] |-> backlight_on)
    else $error("backlight off");
  light_blink_a: assert property (hold_q <= 32'(252 * TICK_CYCLES))
    else $error("backlight not flashing");
  code_shown_a: assert property (disp.ui == ST_ERR && trip_active |-> disp.err_code == trip_cause)
    else $error("wrong error code");
  relay_ind_a: assert property ($stable(relay_close) [*4] |-> disp.relay_closed == relay_close && disp.relay_closed != disp.err_show)
    else $error("relay indicator wrong");
  rot_ind_a: assert property ($stable(phase_order_ok) [*4] |-> disp.rot_ok == phase_order_ok)
    else $error("rotation indicator wrong");
  comm_ind_a: assert property ($stable(comm_active) [*4] |-> disp.comm_on == comm_active)
    else $error("comm indicator wrong");
  bad_addr_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no slave error");
endmodule : pmt_panel_checker

bind pmt_panel pmt_panel_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .trip_active, .trip_cause, .restore_ok,
  .phase_order_ok, .comm_active, .relay_close, .backlight_on, .disp
);
`default_nettype wire

//--- tb/pmt_front_end.sv
// Purpose: Operator buttons and measurement front end
// Assumes: Bench calls its tasks just after a clock edge
// Notes:   Presses bounce before settling
`timescale 1ns/100ps
`default_nettype none
module pmt_front_end
  import pmt_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input  wire logic       pclk,
  output logic      [3:0] btn_n,
  output logic            trip_active,
  output logic      [3:0] trip_cause,
  output logic            restore_ok,
  output logic            phase_order_ok,
  output logic            comm_active
);
  int cnt = 0;

  initial begin
    btn_n = 4'hF;
    trip_active = 1'b0;
    trip_cause = 4'h0;
    restore_ok = 1'b1;
    phase_order_ok = 1'b1;
    comm_active = 1'b0;
  end

  always @(posedge pclk) begin
    cnt <= cnt + 1;
    if (cnt % 300 == 0) phase_order_ok <= ~phase_order_ok;
    if (cnt % 170 == 0) comm_active <= ~comm_active;
  end

  task automatic press(input pmt_btn_t b);
    repeat (3) begin
      @(posedge pclk);
      btn_n[b] <= 1'b0;
      @(posedge pclk);
      btn_n[b] <= 1'b1;
    end
    @(posedge pclk);
    btn_n[b] <= 1'b0;
    repeat (25 * TICK_CYCLES) @(posedge pclk);
    btn_n[b] <= 1'b1;
    repeat (25 * TICK_CYCLES) @(posedge pclk);
  endtask : press

  task automatic trip(input logic [3:0] c);
    trip_cause  <= c;
    trip_active <= 1'b1;
    restore_ok  <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : trip

  task automatic recover(input logic ok);
    trip_active <= 1'b0;
    restore_ok  <= ok;
    repeat (4) @(posedge pclk);
  endtask : recover
endmodule : pmt_front_end
`default_nettype wire

//--- tb/pmt_panel_tb.sv
// Purpose: Self-checking bench of the panel controller
// Assumes: Short tick keeps every slow timer inside the run
// Notes:   Buttons and trips come from the front-end model
`timescale 1ns/100ps
`default_nettype none
module pmt_panel_tb;
  import pmt_pkg::*;
  localparam int TK = 4;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
  logic        relay_close, backlight_on, trip_active, restore_ok, phase_order_ok, comm_active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  btn_n, trip_cause;
  pmt_disp_t   disp;
  int          failures, compares, cyc, n, s, code;
  int          heads[5] = '{1, 5, 9, 14, 19};
  logic [7:0]  roff[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rval[6] = '{32'h0000_0001, 0, 32'h0000_000F, 32'h0000_8000, 0, 0};

  pmt_panel #(.TICK_CYCLES(TK)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .btn_n,
    .trip_active, .trip_cause, .restore_ok, .phase_order_ok, .comm_active, .relay_close,
    .backlight_on, .disp, .irq
  );
  pmt_front_end #(.TICK_CYCLES(TK)) fe (
    .pclk, .btn_n, .trip_active, .trip_cause, .restore_ok, .phase_order_ok, .comm_active
  );

  function automatic logic [6:0] scr_info(input int x);
    logic [2:0] m;
    int b;
    m = 3'h0;
    b = 0;
    for (int i = 0; i < 5; i++) begin
      if (x >= heads[i]) begin
        m = 3'(i + 1);
        b = heads[i];
      end
    end
    return (x == b) ? {m, 4'h0} : {m, 4'(1 << (x - b - 1))};
  endfunction : scr_info

  function automatic int next_head(input int x);
    for (int i = 0; i < 5; i++) begin
      if (heads[i] > x) return heads[i];
    end
    return 0;
  endfunction : next_head

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      $display("[ERR] %0t run timed out", $time);
      results();
    end
  end

  initial begin
    n = $urandom(32'h3691_7ef3);
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({relay_close, disp.screen}, 32'h0000_0020, "power up");
    foreach (roff[i]) begin
      apb(1'b0, roff[i], 0);
      chk(rd, rval[i], "reset value");
    end
    apb(1'b0, 8'h18, 0);
    chk({er, rd[0]}, 2'b10, "unmapped");
    $display("test reset done");
    for (int i = 1; i <= 23; i++) begin
      fe.press(BTN_DOWN);
      chk({disp.screen, disp.meas_type, disp.variant}, {5'(i % 23), scr_info(i % 23)}, "down");
    end
    s = 0;
    repeat (6) begin
      fe.press(BTN_UP);
      s = next_head(s);
      chk(disp.screen, s, "up");
    end
    repeat (3) begin
      n = $urandom_range(22);
      repeat (n) fe.press(BTN_DOWN);
      fe.press(BTN_UP);
      chk(disp.screen, next_head(n), "up from variant");
      repeat (2) fe.press(BTN_DOWN);
      fe.press(BTN_ESC);
      chk(disp.screen, 0, "esc home");
    end
    $display("test screens done");
    code = 2 + $urandom_range(3);
    apb(1'b1, 8'h04, 32'(code));
    apb(1'b1, 8'h14, 32'h0000_0008);
    fe.press(BTN_SET);
    chk(disp.ui, ST_PASS, "password prompt");
    fe.press(BTN_SET);
    chk({disp.ui, irq}, {ST_MEAS, 1'b1}, "wrong password");
    apb(1'b1, 8'h10, 32'h0000_0008);
    @(posedge pclk);
    chk(irq, 0, "irq clear");
    fe.press(BTN_SET);
    repeat (code) fe.press(BTN_UP);
    chk(disp.edit_value, code, "code entry");
    fe.press(BTN_SET);
    chk({disp.ui, disp.menu_group}, {ST_MENU, 3'h0}, "first group");
    fe.press(BTN_DOWN);
    chk(disp.menu_group, 5, "group wrap");
    repeat (5) fe.press(BTN_UP);
    chk(disp.menu_group, 4, "general group");
    fe.press(BTN_SET);
    chk({disp.ui, disp.edit_value}, {ST_EDIT, 8'h0F}, "edit demand");
    fe.press(BTN_DOWN);
    chk(disp.edit_value, 14, "decrement");
    fe.press(BTN_ESC);
    apb(1'b0, 8'h08, 0);
    chk({disp.ui, rd[7:0]}, {ST_MENU, 8'h0F}, "edit discarded");
    fe.press(BTN_SET);
    fe.press(BTN_UP);
    fe.press(BTN_SET);
    apb(1'b0, 8'h08, 0);
    chk({disp.ui, rd[7:0]}, {ST_MENU, 8'h10}, "edit stored");
    fe.press(BTN_ESC);
    chk(disp.ui, ST_MEAS, "esc menu");
    $display("test menu done");
    apb(1'b1, 8'h00, 0);
    apb(1'b1, 8'h14, 32'h0000_0001);
    for (int c = 0; c < 12; c++) begin
      fe.trip(4'(c));
      chk({relay_close, disp.ui, disp.err_code, disp.err_show}, {1'b0, ST_ERR, 4'(c), 1'b1}, "trip");
      apb(1'b0, 8'h0C, 0);
      chk(rd[15:8], {1'b0, 4'(c), ST_ERR}, "trip status");
      if (c == 11) begin
        chk(irq, 1, "trip irq");
        apb(1'b1, 8'h10, 32'h0000_000F);
        fe.recover(1'b0);
        fe.press(BTN_ESC);
        chk({relay_close, disp.ui, disp.err_code, irq}, {1'b0, ST_ERR, 4'hB, 1'b0}, "latched");
      end
      fe.recover(1'b1);
      fe.press(BTN_ESC);
      chk({relay_close, disp.ui, disp.screen}, {1'b1, ST_MEAS, 5'h00}, "manual reset");
    end
    $display("test trips done");
    apb(1'b1, 8'h00, 32'h0000_0003);
    apb(1'b1, 8'h14, 32'h0000_0002);
    apb(1'b1, 8'h10, 32'h0000_000F);
    chk({disp.home_ll, disp.phase_num != 2'd0, irq}, 3'b110, "line-to-line home");
    fe.trip(4'($urandom_range(11)));
    fe.recover(1'b1);
    repeat (2900 * TK) @(posedge pclk);
    chk({relay_close, irq}, 2'b00, "auto early");
    repeat (200 * TK) @(posedge pclk);
    chk({relay_close, irq}, 2'b11, "auto restore");
    $display("test auto done");
    results();
  end
endmodule : pmt_panel_tb
`default_nettype wire
